/* src/adcrd_i2c_slave.sv */
`timescale 1ns/100ps
`include "adcrd_consts.svh"
module adcrd_i2c_slave #(
  parameter int RAW_W = 19,
  parameter int ADDR_W = 7
)
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic conv_done_i,
  input wire logic signed [RAW_W-1:0] conv_raw_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  output logic conv_start_o,
  output logic converting_o,
  output logic sleep_o,
  output logic bus_busy_o,
  output logic [7:0] channel_select_o,
  output adcrd_pkg::adcrd_result_t conversion_result_o
);

  localparam logic signed [RAW_W-1:0] FS_POS = RAW_W'(`ADCRD_FS_LSB);
  localparam logic signed [RAW_W-1:0] FS_NEG = -FS_POS;

  adcrd_line_if line();

  adcrd_pkg::adcrd_state_e state;
  logic [ADDR_W-1:0] addr_meta;
  logic [ADDR_W-1:0] addr_q;
  logic [3:0] bit_cnt;
  logic [1:0] byte_cnt;
  logic [7:0] shift_in;
  adcrd_pkg::adcrd_result_t shift_out;
  logic boot;
  logic pending;
  logic addr_hit;
  logic addr_ack;
  logic full_read;
  logic go;
  logic wr_byte_done;
  logic in_read;

  // Pack raw converter value into the 24-bit output word
  function automatic adcrd_pkg::adcrd_result_t format_result
  (
    input logic signed [RAW_W-1:0] raw
  );
    adcrd_pkg::adcrd_result_t res;
    if (raw >= FS_POS)
    begin
      res = `ADCRD_CLAMP_HI;
    end
    else if (raw < FS_NEG)
    begin
      res = `ADCRD_CLAMP_LO;
    end
    else
    begin
      res = {~raw[16], raw[16:0], {`ADCRD_ZERO_BITS{1'b0}}};
    end
    return res;
  endfunction

  adcrd_line_sync u_sync
  (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .line(line)
  );

  // Address straps come from pins
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      addr_meta <= '0;
      addr_q <= '0;
    end
    else
    begin
      addr_meta <= addr_i;
      addr_q <= addr_meta;
    end
  end

  assign addr_hit = (shift_in[7:1] == addr_q) && !converting_o;

  assign addr_ack = (state == adcrd_pkg::ST_ADDR) && line.scl_fall
    && (bit_cnt == `ADCRD_BYTE_BITS) && addr_hit;

  assign full_read = (state == adcrd_pkg::ST_RD_ACK) && line.scl_rise
    && (byte_cnt == `ADCRD_LAST_BYTE);

  assign wr_byte_done = (state == adcrd_pkg::ST_WR_DATA) && line.scl_fall
    && (bit_cnt == `ADCRD_BYTE_BITS);

  assign go = boot || full_read || (line.stop && pending);

  assign in_read = (state == adcrd_pkg::ST_RD_DATA)
    || (state == adcrd_pkg::ST_RD_ACK)
    || (state == adcrd_pkg::ST_RD_NEXT);

  // Bus busy between start and stop
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      bus_busy_o <= 1'b0;
    end
    else if (line.start)
    begin
      bus_busy_o <= 1'b1;
    end
    else if (line.stop)
    begin
      bus_busy_o <= 1'b0;
    end
  end

  // First conversion runs right after reset
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      boot <= 1'b1;
    end
    else
    begin
      boot <= 1'b0;
    end
  end

  // Access that must end in a conversion once the master stops
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      pending <= 1'b0;
    end
    else if (addr_ack)
    begin
      pending <= 1'b1;
    end
    else if (go)
    begin
      pending <= 1'b0;
    end
  end

  // Conversion start pulse and busy level
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      conv_start_o <= 1'b0;
      converting_o <= 1'b1;
    end
    else
    begin
      conv_start_o <= go;
      if (go)
      begin
        converting_o <= 1'b1;
      end
      else if (conv_done_i)
      begin
        converting_o <= 1'b0;
      end
    end
  end

  // Sleep once done, left after the read address ACK clock, while read data shifts out
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      sleep_o <= 1'b0;
    end
    else
    begin
      sleep_o <= !converting_o && !in_read && !go;
    end
  end

  // Result register
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      conversion_result_o <= `ADCRD_RESULT_RESET;
    end
    else if (conv_done_i && converting_o)
    begin
      conversion_result_o <= format_result(conv_raw_i);
    end
  end

  // Channel register
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      channel_select_o <= `ADCRD_CHAN_RESET;
    end
    else if (wr_byte_done && (shift_in[7:5] == `ADCRD_CHAN_EN))
    begin
      channel_select_o <= shift_in;
    end
  end

  // Open drain: only ever pulls low
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      sda_o <= 1'b0;
    end
    else
    begin
      sda_o <= 1'b0;
    end
  end

  // Serial engine; start and stop only observed, never made
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      state <= adcrd_pkg::ST_IDLE;
      bit_cnt <= 4'h0;
      byte_cnt <= 2'h0;
      shift_in <= 8'h00;
      shift_out <= `ADCRD_RESULT_RESET;
      sda_oe_n_o <= 1'b1;
    end
    else if (line.stop)
    begin
      state <= adcrd_pkg::ST_IDLE;
      sda_oe_n_o <= 1'b1;
    end
    else if (line.start)
    begin
      state <= adcrd_pkg::ST_ADDR;
      bit_cnt <= 4'h0;
      sda_oe_n_o <= 1'b1;
    end
    else
    begin
      unique case (state)
        adcrd_pkg::ST_IDLE:
        begin
          sda_oe_n_o <= 1'b1;
        end
        adcrd_pkg::ST_ADDR:
        begin
          if (line.scl_rise)
          begin
            shift_in <= {shift_in[6:0], line.sda};
            bit_cnt <= bit_cnt + 4'h1;
          end
          else if (line.scl_fall && (bit_cnt == `ADCRD_BYTE_BITS))
          begin
            if (addr_hit)
            begin
              sda_oe_n_o <= 1'b0;
              state <= adcrd_pkg::ST_ADDR_ACK;
            end
            else
            begin
              state <= adcrd_pkg::ST_IDLE;
            end
          end
        end
        adcrd_pkg::ST_ADDR_ACK:
        begin
          if (line.scl_fall)
          begin
            byte_cnt <= 2'h0;
            if (shift_in[0])
            begin
              sda_oe_n_o <= conversion_result_o[`ADCRD_RES_MSB];
              shift_out <= conversion_result_o << 1;
              bit_cnt <= 4'h1;
              state <= adcrd_pkg::ST_RD_DATA;
            end
            else
            begin
              sda_oe_n_o <= 1'b1;
              bit_cnt <= 4'h0;
              state <= adcrd_pkg::ST_WR_DATA;
            end
          end
        end
        adcrd_pkg::ST_WR_DATA:
        begin
          if (line.scl_rise)
          begin
            shift_in <= {shift_in[6:0], line.sda};
            bit_cnt <= bit_cnt + 4'h1;
          end
          else if (wr_byte_done)
          begin
            sda_oe_n_o <= 1'b0;
            state <= adcrd_pkg::ST_WR_ACK;
          end
        end
        adcrd_pkg::ST_WR_ACK:
        begin
          if (line.scl_fall)
          begin
            sda_oe_n_o <= 1'b1;
            bit_cnt <= 4'h0;
            state <= adcrd_pkg::ST_WR_DATA;
          end
        end
        adcrd_pkg::ST_RD_DATA:
        begin
          if (line.scl_fall)
          begin
            if (bit_cnt == `ADCRD_BYTE_BITS)
            begin
              sda_oe_n_o <= 1'b1;
              state <= adcrd_pkg::ST_RD_ACK;
            end
            else
            begin
              sda_oe_n_o <= shift_out[`ADCRD_RES_MSB];
              shift_out <= shift_out << 1;
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
        end
        adcrd_pkg::ST_RD_ACK:
        begin
          if (line.scl_rise)
          begin
            byte_cnt <= byte_cnt + 2'h1;
            if (line.sda || (byte_cnt == `ADCRD_LAST_BYTE))
            begin
              state <= adcrd_pkg::ST_IDLE;
            end
            else
            begin
              state <= adcrd_pkg::ST_RD_NEXT;
            end
          end
        end
        adcrd_pkg::ST_RD_NEXT:
        begin
          if (line.scl_fall)
          begin
            sda_oe_n_o <= shift_out[`ADCRD_RES_MSB];
            shift_out <= shift_out << 1;
            bit_cnt <= 4'h1;
            state <= adcrd_pkg::ST_RD_DATA;
          end
        end
      endcase
    end
  end

endmodule

/* pkg/adcrd_consts.svh */
`ifndef ADCRD_CONSTS_SVH
`define ADCRD_CONSTS_SVH
`define ADCRD_BYTE_BITS 4'h8
`define ADCRD_LAST_BYTE 2'h2
`define ADCRD_RES_W 24
`define ADCRD_RES_MSB 23
`define ADCRD_ZERO_BITS 6
`define ADCRD_FS_LSB 32'h0001_0000
`define ADCRD_CLAMP_HI 24'hC0_0000
`define ADCRD_CLAMP_LO 24'h3F_FFC0
`define ADCRD_CHAN_RESET 8'h00
`define ADCRD_CHAN_EN 3'h5
`define ADCRD_RESULT_RESET 24'h00_0000
`endif

/* pkg/adcrd_pkg.sv */
package adcrd_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_WR_DATA,
    ST_WR_ACK,
    ST_RD_DATA,
    ST_RD_ACK,
    ST_RD_NEXT
  } adcrd_state_e;

  typedef logic [23:0] adcrd_result_t;

endpackage

/* pkg/adcrd_line_if.sv */
`timescale 1ns/100ps
interface adcrd_line_if;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;

  modport src
  (
    output scl, sda, scl_rise, scl_fall, start, stop
  );

  modport dst
  (
    input scl, sda, scl_rise, scl_fall, start, stop
  );
endinterface

/* src/adcrd_line_sync.sv */
`timescale 1ns/100ps
module adcrd_line_sync
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  adcrd_line_if.src line
);

  logic scl_meta;
  logic scl_q;
  logic scl_d;
  logic sda_meta;
  logic sda_q;
  logic sda_d;

  // Idle bus reads high on both lines
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      scl_meta <= 1'b1;
      scl_q <= 1'b1;
      scl_d <= 1'b1;
      sda_meta <= 1'b1;
      sda_q <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      scl_meta <= scl_i;
      scl_q <= scl_meta;
      scl_d <= scl_q;
      sda_meta <= sda_i;
      sda_q <= sda_meta;
      sda_d <= sda_q;
    end
  end

  assign line.scl = scl_q;
  assign line.sda = sda_q;
  assign line.scl_rise = scl_q & ~scl_d;
  assign line.scl_fall = ~scl_q & scl_d;
  assign line.start = scl_q & scl_d & sda_d & ~sda_q;
  assign line.stop = scl_q & scl_d & ~sda_d & sda_q;

endmodule

/* verif/adcrd_master.sv */
`timescale 1ns/100ps
module adcrd_master
(
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // Also serves as repeated start
  task automatic start();
    #100 sda_o = 1'b1;
    #400 scl_o = 1'b1;
    #400 sda_o = 1'b0;
    #400 scl_o = 1'b0;
  endtask

  task automatic stop();
    #100 sda_o = 1'b0;
    #400 scl_o = 1'b1;
    #400 sda_o = 1'b1;
    #400;
  endtask

  // Nine clocks MSB first; a 1 releases SDA
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--)
    begin
      #100 sda_o = tx[i];
      #300 scl_o = 1'b1;
      #200 rx[i] = sda_i;
      #200 scl_o = 1'b0;
    end
  endtask
endmodule

/* verif/adcrd_i2c_slave_sva.sv */
`timescale 1ns/100ps
`include "adcrd_consts.svh"
module adcrd_i2c_slave_sva #(
  parameter int RAW_W = 19,
  parameter int ADDR_W = 7
)
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic scl_i,
  input wire logic conv_done_i,
  input wire logic signed [RAW_W-1:0] conv_raw_i,
  input wire logic sda_oe_n_o,
  input wire logic conv_start_o,
  input wire logic converting_o,
  input wire logic sleep_o,
  input wire adcrd_pkg::adcrd_result_t conversion_result_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  logic take;
  logic [23:0] code;
  assign take = conv_done_i && converting_o && !conv_start_o;
  assign code = {~conv_raw_i[16], conv_raw_i[16:0], 6'h00};

  oe_scl_low_a: assert property (
    $changed(sda_oe_n_o) |-> !$past(scl_i, 2))
    else $error("sda enable changed while scl high");
  start_conv_a: assert property (
    conv_start_o |=> converting_o && !conv_start_o)
    else $error("conversion start not followed by conversion");
  busy_nak_a: assert property (
    converting_o && $past(converting_o) |-> sda_oe_n_o)
    else $error("sda pulled during conversion");
  done_sleep_a: assert property (
    take |=> !converting_o ##1 sleep_o)
    else $error("done strobe not followed by sleep");
  sleep_idle_a: assert property (
    sleep_o |-> !converting_o)
    else $error("sleep while converting");
  clamp_hi_a: assert property (
    take && conv_raw_i >= 65536 |=> conversion_result_o == `ADCRD_CLAMP_HI)
    else $error("over range clamp wrong");
  clamp_lo_a: assert property (
    take && conv_raw_i < -65536 |=> conversion_result_o == `ADCRD_CLAMP_LO)
    else $error("under range clamp wrong");
  code_fmt_a: assert property (
    take && conv_raw_i < 65536 && conv_raw_i >= -65536
    |=> conversion_result_o == $past(code))
    else $error("result code wrong");
  low_zero_a: assert property (
    conversion_result_o[5:0] == 6'h00)
    else $error("low result bits not zero");
  start_pulse_a: assert property (
    $rose(converting_o) |-> conv_start_o)
    else $error("conversion began without start pulse");
endmodule

bind adcrd_i2c_slave adcrd_i2c_slave_sva #(
  .RAW_W(RAW_W),
  .ADDR_W(ADDR_W)
) sva_i (
  .clk_i(clk_i),
  .reset_n_i(reset_n_i),
  .scl_i(scl_i),
  .conv_done_i(conv_done_i),
  .conv_raw_i(conv_raw_i),
  .sda_oe_n_o(sda_oe_n_o),
  .conv_start_o(conv_start_o),
  .converting_o(converting_o),
  .sleep_o(sleep_o),
  .conversion_result_o(conversion_result_o)
);

/* verif/adc_i2c_result_readout_tb.sv */
`timescale 1ns/100ps
module adc_i2c_result_readout_tb;
  localparam logic [6:0] ADDR = 7'h14;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic done = 1'b0;
  logic signed [18:0] raw = 19'h00000;
  logic [6:0] addr = ADDR;
  logic scl, sda_m, sda, sda_d, oe_n, start_p, conv, slp, busy;
  logic [7:0] chan;
  adcrd_pkg::adcrd_result_t result;
  logic [8:0] rx;
  logic [23:0] v;
  int failures = 0;
  int checks = 0;
  int cycles = 0;
  // Raw input beside expected result code
  logic [42:0] rows [8] = '{{19'h10000, 24'hC00000},
    {19'h11170, 24'hC00000}, {19'h0FFFF, 24'hBFFFC0},
    {19'h08000, 24'hA00000}, {19'h00000, 24'h800000},
    {19'h7FFFF, 24'h7FFFC0}, {19'h70000, 24'h400000},
    {19'h6EE90, 24'h3FFFC0}};

  // Open drain with pull-up
  assign sda = sda_m & (oe_n | sda_d);

  adcrd_master m (.sda_i(sda), .scl_o(scl), .sda_o(sda_m));

  adcrd_i2c_slave uut (.clk_i(clk), .reset_n_i(reset_n), .scl_i(scl),
    .sda_i(sda), .addr_i(addr), .conv_done_i(done), .conv_raw_i(raw),
    .sda_o(sda_d), .sda_oe_n_o(oe_n), .conv_start_o(start_p),
    .converting_o(conv), .sleep_o(slp), .bus_busy_o(busy),
    .channel_select_o(chan), .conversion_result_o(result));

  initial
  begin
    forever #50 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      failures++;
      complete_run();
    end
  end

  task automatic complete_run();
    if (failures == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic cmp(input string n, input logic [23:0] e, s);
    checks++;
    if (s !== e)
    begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic rst();
    reset_n = 1'b0;
    repeat (6) @(negedge clk);
    cmp("channel", 24'h0, chan);
    cmp("result", 24'h0, result);
    reset_n = 1'b1;
  endtask

  task automatic finish_conv(input logic [18:0] r);
    repeat (2) @(negedge clk);
    done = 1'b1;
    raw = r;
    @(negedge clk);
    done = 1'b0;
    @(negedge clk);
    cmp("sleep", 24'h1, slp);
  endtask

  task automatic addr_byte(input logic rw, input logic a);
    m.xfer({addr ^ 7'(a), rw, 1'b1}, rx);
  endtask

  initial
  begin
    rst();
    foreach (rows[i])
    begin
      finish_conv(rows[i][42:24]);
      m.start();
      cmp("busy", 24'h1, busy);
      addr_byte(1'b1, 1'b0);
      cmp("addr ack", 24'h0, rx[0]);
      for (int b = 0; b < 3; b++)
      begin
        m.xfer({8'hFF, b == 2}, rx);
        v = {v[15:0], rx[8:1]};
        if (b == 0)
        begin
          cmp("sleep", 24'h0, slp);
        end
      end
      cmp("result code", rows[i][23:0], v);
      cmp("converting", 24'h1, conv);
      m.stop();
      cmp("busy", 24'h0, busy);
    end
    m.start();
    addr_byte(1'b1, 1'b0);
    cmp("nak busy", 24'h1, rx[0]);
    m.stop();
    finish_conv(19'h00000);
    m.start();
    addr_byte(1'b1, 1'b1);
    cmp("nak other", 24'h1, rx[0]);
    m.stop();
    cmp("idle", 24'h0, conv);
    // New strap value must be obeyed, cut read then restarts
    addr = 7'h6B;
    m.start();
    addr_byte(1'b1, 1'b0);
    cmp("pin address", 24'h0, rx[0]);
    m.stop();
    cmp("converting", 24'h1, conv);
    addr = ADDR;
    finish_conv(19'h00000);
    for (int w = 0; w < 3; w++)
    begin
      m.start();
      addr_byte(1'b0, 1'b0);
      m.xfer({w == 0 ? 8'hA3 : w == 1 ? 8'h1F : 8'h9E, 1'b1}, rx);
      cmp("write ack", 24'h0, rx[0]);
      if (w == 0)
      begin
        m.start();
        addr_byte(1'b1, 1'b0);
        m.xfer(9'h1FF, rx);
        cmp("first byte", 24'h80, rx[8:1]);
      end
      m.stop();
      cmp("channel", 24'hA3, chan);
      cmp("converting", 24'h1, conv);
      finish_conv(19'h00000);
    end
    rst();
    cmp("converting", 24'h1, conv);
    complete_run();
  end
endmodule
